// ===== rtl/dcscb_pkg.sv
// Behaviour
// - A write-through store that hits an M, E or S line updates the cache copy and also issues a write-with-flush transfer (00010) with the page attributes.
// - A write-through, coherence-required store that misses writes only to memory with write-with-flush and never allocates or fills the line.
// - A store-conditional to a cacheable write-back page that misses with the reservation held issues an atomic read-for-ownership (11110), then clears the reservation, reports success, writes the data and marks the line modified.
// - A store-conditional with a held reservation that hits a shared write-back line broadcasts a kill (01100), waits for it to complete without retry, then clears the reservation, reports, writes and marks modified.
// - A store-conditional with a held reservation to a caching-inhibited page issues an atomic write-with-flush (10010) to memory, then clears the reservation and reports, flagging a valid line there as inconsistent.
// - A store-conditional to a write-through page raises a data access exception and starts no bus transaction.
package dcscb_pkg;
  // line coherence states
  typedef enum logic [1:0] {
    DCSCB_INV = 2'b00,
    DCSCB_SHR = 2'b01,
    DCSCB_EXC = 2'b10,
    DCSCB_MOD = 2'b11
  } dcscb_mesi_type;

  // bus transfer type codes
  localparam logic [4:0] TT_WRITE_FLUSH = 5'h02;
  localparam logic [4:0] TT_KILL = 5'h0C;
  localparam logic [4:0] TT_READ_OWN_ATOMIC = 5'h1E;
  localparam logic [4:0] TT_WRITE_FLUSH_ATOMIC = 5'h12;
  localparam logic [4:0] TT_NONE = 5'h00;

  // page attribute bit positions (write-through, inhibited, coherent)
  localparam int ATTR_W_BIT = 2;
  localparam int ATTR_I_BIT = 1;
  localparam int ATTR_M_BIT = 0;

  // reset values
  localparam logic RSV_RESET = 1'b0;
endpackage

// ===== rtl/dcscb_sync2.sv
`timescale 1ns/1ps
module dcscb_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // level in and out
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  if (WIDTH < 1) begin : g_width_check
    $error("dcscb_sync2 width must be at least one");
  end

  always_comb begin
    meta_d = async;
    sync_d = meta_q;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync = sync_q;
endmodule

// ===== rtl/dcscb_ctrl.sv
`timescale 1ns/1ps
module dcscb_ctrl (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // request from the load/store unit
  input wire logic reqValid,
  input wire logic reqIsStcx,
  input wire logic [2:0] pageStorageAttributes,
  input wire logic [1:0] lineState,
  output logic reqBusy,
  // answer to the load/store unit
  output logic doneValid,
  output logic condSuccess,
  output logic condValid,
  output logic dataAccessExc,
  output logic paradoxFlag,
  // cache array update
  output logic cacheWrite,
  output logic [1:0] cacheNewState,
  output logic cacheUpdate,
  // reservation
  input wire logic rsvSet,
  output logic rsvHeld,
  // system bus (pins)
  output logic busReq,
  output logic [4:0] busTransferType,
  output logic [2:0] busAttr,
  input wire logic busAckPin,
  input wire logic snoopAddressRetryPin,
  input wire logic snoopSharedHitPin
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUS = 2'b01,
    ST_DONE = 2'b10
  } dcscb_state_type;

  logic [2:0] pinSync;
  logic busAck;
  logic snoopRetry;
  logic snoopShared;

  dcscb_sync2 #(.WIDTH(3)) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .async({busAckPin, snoopAddressRetryPin, snoopSharedHitPin}),
    .sync(pinSync)
  );
  assign busAck = pinSync[2];
  assign snoopRetry = pinSync[1];
  // shared alone changes nothing for these stores
  assign snoopShared = pinSync[0];

  dcscb_state_type state_q, state_d;
  logic rsv_q, rsv_d;
  logic busReq_q, busReq_d;
  logic [4:0] tt_q, tt_d;
  logic [2:0] attr_q, attr_d;
  logic isStcx_q, isStcx_d;
  logic [1:0] line_q, line_d;
  logic done_q, done_d;
  logic cond_q, cond_d;
  logic condV_q, condV_d;
  logic exc_q, exc_d;
  logic par_q, par_d;
  logic cw_q, cw_d;
  logic cu_q, cu_d;
  logic [1:0] ns_q, ns_d;
  logic busy_q, busy_d;

  logic wt, ci, hit;
  assign wt = pageStorageAttributes[dcscb_pkg::ATTR_W_BIT];
  assign ci = pageStorageAttributes[dcscb_pkg::ATTR_I_BIT];
  assign hit = lineState != dcscb_pkg::DCSCB_INV;

  always_comb begin
    state_d = state_q;
    rsv_d = rsv_q | rsvSet;
    busReq_d = busReq_q;
    tt_d = tt_q;
    attr_d = attr_q;
    isStcx_d = isStcx_q;
    line_d = line_q;
    done_d = 1'b0;
    cond_d = cond_q;
    condV_d = 1'b0;
    exc_d = 1'b0;
    par_d = 1'b0;
    cw_d = 1'b0;
    cu_d = 1'b0;
    ns_d = ns_q;
    case (state_q)
      ST_IDLE: begin
        if (reqValid && !busy_q) begin
          attr_d = pageStorageAttributes;
          isStcx_d = reqIsStcx;
          line_d = lineState;
          if (reqIsStcx && wt) begin
            exc_d = 1'b1;
            done_d = 1'b1;
          end else if (reqIsStcx && !rsv_q) begin
            cond_d = 1'b0;
            condV_d = 1'b1;
            done_d = 1'b1;
            par_d = ci && hit;
          end else if (reqIsStcx && ci) begin
            tt_d = dcscb_pkg::TT_WRITE_FLUSH_ATOMIC;
            par_d = hit;
            busReq_d = 1'b1;
            state_d = ST_BUS;
          end else if (reqIsStcx && !hit) begin
            tt_d = dcscb_pkg::TT_READ_OWN_ATOMIC;
            busReq_d = 1'b1;
            state_d = ST_BUS;
          end else if (reqIsStcx && lineState == dcscb_pkg::DCSCB_SHR) begin
            tt_d = dcscb_pkg::TT_KILL;
            busReq_d = 1'b1;
            state_d = ST_BUS;
          end else if (reqIsStcx) begin
            // a reserve arriving now wins over the clear
            rsv_d = rsvSet;
            cond_d = 1'b1;
            condV_d = 1'b1;
            cw_d = 1'b1;
            cu_d = 1'b1;
            ns_d = dcscb_pkg::DCSCB_MOD;
            done_d = 1'b1;
          end else begin
            // plain write-through store, hit or miss
            tt_d = dcscb_pkg::TT_WRITE_FLUSH;
            busReq_d = 1'b1;
            state_d = ST_BUS;
          end
        end
      end
      ST_BUS: begin
        if (busAck) begin
          busReq_d = 1'b0;
          state_d = ST_DONE;
          if (snoopRetry) begin
            // reservation untouched; requester must reissue
            state_d = ST_IDLE;
          end else if (!isStcx_q) begin
            // plain store: a hit writes the cached copy, a miss goes to memory only, no allocate
            cw_d = line_q != dcscb_pkg::DCSCB_INV;
            ns_d = line_q;
          end else begin
            rsv_d = rsvSet;
            cond_d = 1'b1;
            condV_d = 1'b1;
            cw_d = !attr_q[dcscb_pkg::ATTR_I_BIT];
            cu_d = !attr_q[dcscb_pkg::ATTR_I_BIT];
            ns_d = dcscb_pkg::DCSCB_MOD;
          end
        end
      end
      ST_DONE: begin
        done_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // a stale synced ack would end the next transfer at once
    busy_d = (state_d != ST_IDLE) || busAck;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      rsv_q <= dcscb_pkg::RSV_RESET;
      busReq_q <= 1'b0;
      tt_q <= dcscb_pkg::TT_NONE;
      attr_q <= 3'h0;
      isStcx_q <= 1'b0;
      line_q <= 2'h0;
      done_q <= 1'b0;
      cond_q <= 1'b0;
      condV_q <= 1'b0;
      exc_q <= 1'b0;
      par_q <= 1'b0;
      cw_q <= 1'b0;
      cu_q <= 1'b0;
      ns_q <= 2'h0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      rsv_q <= rsv_d;
      busReq_q <= busReq_d;
      tt_q <= tt_d;
      attr_q <= attr_d;
      isStcx_q <= isStcx_d;
      line_q <= line_d;
      done_q <= done_d;
      cond_q <= cond_d;
      condV_q <= condV_d;
      exc_q <= exc_d;
      par_q <= par_d;
      cw_q <= cw_d;
      cu_q <= cu_d;
      ns_q <= ns_d;
      busy_q <= busy_d;
    end
  end

  assign reqBusy = busy_q;
  assign doneValid = done_q;
  assign condSuccess = cond_q;
  assign condValid = condV_q;
  assign dataAccessExc = exc_q;
  assign paradoxFlag = par_q;
  assign cacheWrite = cw_q;
  assign cacheUpdate = cu_q;
  assign cacheNewState = ns_q;
  assign rsvHeld = rsv_q;
  assign busReq = busReq_q;
  assign busTransferType = tt_q;
  assign busAttr = attr_q;

  property p_exc_no_bus;
    @(posedge mclk) disable iff (!rst_b)
      (!busy_q && reqValid && reqIsStcx && wt)
      |=> (dataAccessExc && !busReq);
  endproperty
  a_exc_no_bus: assert property (p_exc_no_bus)
    else $error("write-through conditional store reached the bus");

  property p_retry_keeps_rsv;
    @(posedge mclk) disable iff (!rst_b)
      (state_q == ST_BUS && busAck && snoopRetry && !rsvSet)
      |=> ($stable(rsv_q) && !busReq && !condValid);
  endproperty
  a_retry_keeps_rsv: assert property (p_retry_keeps_rsv)
    else $error("retry changed reservation or kept bus");

  property p_stcx_success_clears;
    @(posedge mclk) disable iff (!rst_b)
      (state_q == ST_BUS && busAck && !snoopRetry && isStcx_q)
      |=> (rsv_q == $past(rsvSet) && condSuccess && condValid) ##1 doneValid;
  endproperty
  a_stcx_success_clears: assert property (p_stcx_success_clears)
    else $error("conditional store did not clear reservation");

  property p_kill_type;
    @(posedge mclk) disable iff (!rst_b)
      (!busy_q && reqValid && reqIsStcx && rsv_q && !wt && !ci
       && lineState == dcscb_pkg::DCSCB_SHR)
      |=> (busReq && busTransferType == 5'h0C);
  endproperty
  a_kill_type: assert property (p_kill_type)
    else $error("shared hit conditional store did not kill");

  property p_ci_type;
    @(posedge mclk) disable iff (!rst_b)
      (!busy_q && reqValid && reqIsStcx && rsv_q && !wt && ci)
      |=> (busReq && busTransferType == 5'h12);
  endproperty
  a_ci_type: assert property (p_ci_type)
    else $error("inhibited conditional store wrong transfer");

  property p_wt_store;
    @(posedge mclk) disable iff (!rst_b)
      (!busy_q && reqValid && !reqIsStcx)
      |=> (busReq && busTransferType == 5'h02);
  endproperty
  a_wt_store: assert property (p_wt_store)
    else $error("write-through store did not write with flush");

  property p_miss_no_fill;
    @(posedge mclk) disable iff (!rst_b)
      (state_q == ST_BUS && busAck && !isStcx_q
       && line_q == dcscb_pkg::DCSCB_INV) |=> !cacheWrite && !cacheUpdate;
  endproperty
  a_miss_no_fill: assert property (p_miss_no_fill)
    else $error("write-through miss allocated a line");

  property p_miss_own;
    @(posedge mclk) disable iff (!rst_b)
      (!busy_q && reqValid && reqIsStcx && rsv_q && !wt && !ci
       && lineState == dcscb_pkg::DCSCB_INV)
      |=> (busReq && busTransferType == 5'h1E);
  endproperty
  a_miss_own: assert property (p_miss_own)
    else $error("conditional miss did not read for ownership");

  property p_retry_shared;
    @(posedge mclk) disable iff (!rst_b)
      (state_q == ST_BUS && busAck && snoopRetry && snoopShared)
      |=> ((!busReq && !doneValid && !condValid) ##1 !doneValid);
  endproperty
  a_retry_shared: assert property (p_retry_shared)
    else $error("retry with shared did not release the bus");
endmodule

// ===== test/dcscb_bus_model.sv
`timescale 1ns/1ps
module dcscb_bus_model (
  // clock and bus pins
  input wire logic mclk,
  input wire logic busReq,
  output logic busAckPin,
  output logic snoopAddressRetryPin,
  output logic snoopSharedHitPin,
  // behaviour chosen by the bench
  input wire logic retryMode,
  input wire logic [3:0] ackDelay
);
  logic [3:0] waitCnt;

  // answer held until the master lets go, then dropped at once
  always @(posedge mclk) begin
    if (busReq !== 1'h1) begin
      waitCnt <= 4'h0;
      busAckPin <= 1'h0;
      snoopAddressRetryPin <= 1'h0;
      snoopSharedHitPin <= 1'h0;
    end else if (waitCnt == ackDelay) begin
      busAckPin <= 1'h1;
      snoopAddressRetryPin <= retryMode;
      // shared rides along on odd delays, with or without retry
      snoopSharedHitPin <= ackDelay[0];
    end else begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
  logic mclk, rst_b, reqValid, reqIsStcx, rsvSet, retryMode;
  logic [2:0] pageStorageAttributes, busAttr, sawAttr;
  logic [1:0] lineState, cacheNewState, sawState;
  logic [4:0] busTransferType, sawTt;
  logic [3:0] ackDelay;
  logic reqBusy, doneValid, condSuccess, condValid, dataAccessExc;
  logic paradoxFlag, cacheWrite, cacheUpdate, rsvHeld, busReq;
  logic busAckPin, snoopAddressRetryPin, snoopSharedHitPin;
  logic sawBusy;
  logic sawBus, sawDone, sawCond, sawSucc, sawWr, sawUpd, sawExc, sawPdx;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;

  dcscb_ctrl dut (.mclk(mclk), .rst_b(rst_b), .reqValid(reqValid),
    .reqIsStcx(reqIsStcx), .pageStorageAttributes(pageStorageAttributes),
    .lineState(lineState), .reqBusy(reqBusy), .doneValid(doneValid),
    .condSuccess(condSuccess), .condValid(condValid),
    .dataAccessExc(dataAccessExc), .paradoxFlag(paradoxFlag),
    .cacheWrite(cacheWrite), .cacheNewState(cacheNewState),
    .cacheUpdate(cacheUpdate), .rsvSet(rsvSet), .rsvHeld(rsvHeld),
    .busReq(busReq), .busTransferType(busTransferType), .busAttr(busAttr),
    .busAckPin(busAckPin), .snoopAddressRetryPin(snoopAddressRetryPin),
    .snoopSharedHitPin(snoopSharedHitPin));

  dcscb_bus_model bus (.mclk(mclk), .busReq(busReq), .busAckPin(busAckPin),
    .snoopAddressRetryPin(snoopAddressRetryPin),
    .snoopSharedHitPin(snoopSharedHitPin), .retryMode(retryMode),
    .ackDelay(ackDelay));

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  task automatic complete_run();
    $display("compares %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic take_rsv();
    @(negedge mclk);
    rsvSet = 1'h1;
    @(negedge mclk);
    rsvSet = 1'h0;
  endtask

  // one request; idle gap first so stale synced acks have drained
  task automatic issue(input logic stcx, input logic [2:0] attrs,
                       input logic [1:0] st);
    {sawBus, sawTt, sawAttr, sawDone, sawCond, sawSucc} = '0;
    {sawWr, sawUpd, sawState, sawExc, sawPdx, sawBusy} = '0;
    repeat (4) @(negedge mclk);
    reqValid = 1'h1;
    reqIsStcx = stcx;
    pageStorageAttributes = attrs;
    lineState = st;
    @(negedge mclk);
    reqValid = 1'h0;
    for (int i = 0; i < 24 && !sawDone; i++) begin
      if (busReq === 1'h1) begin
        sawBus = 1'h1;
        sawTt = busTransferType;
        sawAttr = busAttr;
      end
      if (cacheUpdate === 1'h1) sawState = cacheNewState;
      sawDone |= doneValid;
      sawCond |= condValid;
      sawSucc |= condValid & condSuccess;
      sawWr |= cacheWrite;
      sawUpd |= cacheUpdate;
      sawExc |= dataAccessExc;
      sawPdx |= paradoxFlag;
      sawBusy |= reqBusy;
      @(negedge mclk);
    end
  endtask

  // flags: done cond succ write upd state[2] exc paradox rsvHeld
  task automatic chk(input logic [4:0] tt, input logic [2:0] a,
                     input logic [9:0] f, input logic [18:0] m);
    logic [18:0] got, want;
    got = {sawBus, sawTt, sawAttr, sawDone, sawCond, sawSucc, sawWr,
           sawUpd, sawState, sawExc, sawPdx, rsvHeld};
    want = {tt != 5'h00, tt, a, f};
    checked++;
    if ((got & m) !== (want & m)) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
    // a bus transfer keeps the block busy, a local answer does not
    checked++;
    if (sawBusy !== (tt != 5'h00)) begin
      bad_count++;
      $display("BAD %0t busy flag %b", $time, sawBusy);
    end
  endtask

  task automatic t_wt_hit();
    for (int w = 4; w < 6; w++) begin
      for (int s = 1; s < 4; s++) begin
        issue(1'h0, 3'(w), 2'(s));
        chk(dcscb_pkg::TT_WRITE_FLUSH, 3'(w), 10'h240, 19'h7_ffc7);
      end
    end
    $display("end wt_hit");
  endtask

  task automatic t_wt_miss();
    issue(1'h0, 3'h5, 2'h0);
    chk(dcscb_pkg::TT_WRITE_FLUSH, 3'h5, 10'h200, 19'h7_ffff);
    $display("end wt_miss");
  endtask

  task automatic t_stcx_miss();
    issue(1'h1, 3'h0, 2'h0);
    chk(dcscb_pkg::TT_NONE, 3'h0, 10'h300, 19'h7_ffff);
    issue(1'h1, 3'h2, 2'h1);
    chk(dcscb_pkg::TT_NONE, 3'h0, 10'h302, 19'h7_ffff);
    for (int w = 0; w < 2; w++) begin
      take_rsv();
      issue(1'h1, 3'(w), 2'h0);
      chk(dcscb_pkg::TT_READ_OWN_ATOMIC, 3'(w), 10'h3f8,
          19'h7_ffff);
    end
    $display("end stcx_miss");
  endtask

  task automatic t_stcx_hit();
    for (int s = 2; s < 4; s++) begin
      take_rsv();
      issue(1'h1, 3'(s - 2), 2'(s));
      chk(dcscb_pkg::TT_NONE, 3'h0, 10'h3f8, 19'h7_ffff);
    end
    $display("end stcx_hit");
  endtask

  task automatic t_stcx_shared();
    ackDelay = 4'h7;
    take_rsv();
    issue(1'h1, 3'h0, 2'h1);
    chk(dcscb_pkg::TT_KILL, 3'h0, 10'h3f8, 19'h7_ffff);
    ackDelay = 4'h1;
    $display("end stcx_shared");
  endtask

  task automatic t_stcx_inhibit();
    take_rsv();
    issue(1'h1, 3'h2, 2'h0);
    chk(dcscb_pkg::TT_WRITE_FLUSH_ATOMIC, 3'h2, 10'h380,
        19'h7_ffff);
    take_rsv();
    issue(1'h1, 3'h3, 2'h2);
    chk(dcscb_pkg::TT_WRITE_FLUSH_ATOMIC, 3'h3, 10'h382,
        19'h7_ffc7);
    $display("end stcx_inhibit");
  endtask

  task automatic t_stcx_wt();
    take_rsv();
    for (int w = 4; w < 8; w++) begin
      issue(1'h1, 3'(w), 2'h0);
      chk(dcscb_pkg::TT_NONE, 3'h0, 10'h004, 19'h7_fc04);
    end
    $display("end stcx_wt");
  endtask

  task automatic t_retry();
    retryMode = 1'h1;
    // odd delay: shared rides along with the retry
    ackDelay = 4'h3;
    take_rsv();
    issue(1'h1, 3'h0, 2'h0);
    chk(dcscb_pkg::TT_READ_OWN_ATOMIC, 3'h0, 10'h001, 19'h7_ffff);
    retryMode = 1'h0;
    issue(1'h1, 3'h0, 2'h0);
    chk(dcscb_pkg::TT_READ_OWN_ATOMIC, 3'h0, 10'h3f8, 19'h7_ffff);
    ackDelay = 4'h1;
    $display("end retry");
  endtask

  initial begin
    rst_b = 1'h0;
    reqValid = 1'h0;
    reqIsStcx = 1'h0;
    rsvSet = 1'h0;
    retryMode = 1'h0;
    ackDelay = 4'h1;
    pageStorageAttributes = 3'h0;
    lineState = 2'h0;
    repeat (12) @(negedge mclk);
    rst_b = 1'h1;
    t_wt_hit();
    t_wt_miss();
    t_stcx_miss();
    t_stcx_hit();
    t_stcx_shared();
    t_stcx_inhibit();
    t_stcx_wt();
    t_retry();
    complete_run();
  end
endmodule
